// *** verilog/pll_clock_defines.svh ***
// register offsets, field positions, reset values and counts of the sampling-clock block
// assumes a 4-bit byte address on the plain register port, 32-bit data
`ifndef PLL_CLOCK_DEFINES_SVH
`define PLL_CLOCK_DEFINES_SVH

// ============================================================
// register offsets (byte addresses)
`define REG_LOOP_CTRL 4'h0
`define REG_LOOP_STATUS 4'h4
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'hC

// ============================================================
// control register fields and reset value
`define CTRL_W 7
`define CTRL_RESET 7'h00
`define IRQ_W 3

// ============================================================
// status register fields
`define STAT_BYPASS_BIT 0
`define STAT_LOCK_BIT 3
`define STAT_VCO_LSB 8
`define STAT_TOTAL_LSB 16

// ============================================================
// interrupt bits
`define IRQ_LOCK_GAINED 0
`define IRQ_LOCK_LOST 1
`define IRQ_RATE_LIMIT 2

// ============================================================
// divider ratios and lock detection counts
`define FB_RATIO_BASE 5'h10
`define FB_RATIO_STEP 5'h04
`define LOCK_WINDOW 5'h10
`define LOCK_GOOD_WINDOWS 3'h4
`define FACTOR_SCALE_SHIFT 2

`endif

// *** verilog/pll_clock_pkg.sv ***
// types shared by the sampling-clock block and its helpers
// assumes the defines header is included by the design files
package pll_clock_pkg;

    // ============================================================
    // divider selections
    typedef enum logic [1:0] {REF_DIV_1, REF_DIV_2, REF_DIV_4, REF_DIV_8} ref_sel_t;
    typedef enum logic [1:0] {FB_DIV_16, FB_DIV_20, FB_DIV_24, FB_DIV_28} fb_sel_t;

    // ============================================================
    // control register layout, msb first
    typedef struct packed {
        logic band_high;
        logic post_div2;
        fb_sel_t fb_sel;
        ref_sel_t ref_sel;
        logic loop_en;
    } ctrl_t;

    // ============================================================
    // state of the top module
    typedef struct packed {
        ctrl_t ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic irq;
        logic sample_out;
        logic level_prev;
        logic lock_prev;
        logic clear;
        logic band_out;
        logic loop_out;
    } top_state_t;

endpackage

// *** verilog/div_if.sv ***
// carrier between the top and a programmable tick divider
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface div_if;
    logic tick_in;
    logic [4:0] ratio;
    logic clear;
    logic tick_out;
    modport ctrl (output tick_in, output ratio, output clear, input tick_out);
    modport div (input tick_in, input ratio, input clear, output tick_out);
endinterface

// *** verilog/tick_divider.sv ***
// programmable divider: one output pulse per ratio input pulses
// assumes ratio is at least one and held steady between clears
`timescale 1ns/1ps
module tick_divider
    import pll_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    div_if.div port
);
    typedef struct packed {
        logic [4:0] count;
        logic tick;
    } div_state_t;

    div_state_t st;
    div_state_t next_st;

    // ============================================================
    // count input pulses, wrap at ratio
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (port.clear) begin
            next_st.count = 5'h00;
        end else if (port.tick_in) begin
            if (st.count >= port.ratio - 5'h01) begin
                next_st.count = 5'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.count = st.count + 5'h01;
            end
        end
    end

    // register the state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.tick_out = st.tick;
endmodule

// *** verilog/lock_detect.sv ***
// lock detector: compares divided reference and feedback pulses per window
// assumes both pulse trains are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`include "pll_clock_defines.svh"
module lock_detect
    import pll_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic ref_tick,
    input wire logic fb_tick,
    output logic locked
);
    typedef struct packed {
        logic [4:0] ref_count;
        logic [5:0] fb_count;
        logic [2:0] good;
        logic locked;
    } lock_state_t;

    lock_state_t st;
    lock_state_t next_st;
    logic [5:0] fb_now;

    // ============================================================
    // a window is good when feedback count is within one of the reference
    always_comb begin
        next_st = st;
        fb_now = st.fb_count + {5'h00, fb_tick};
        next_st.fb_count = fb_now;
        if (clear) begin
            next_st = '0;
        end else if (ref_tick) begin
            if (st.ref_count == `LOCK_WINDOW - 5'h01) begin
                next_st.ref_count = 5'h00;
                next_st.fb_count = 6'h00;
                if (fb_now >= {1'b0, `LOCK_WINDOW} - 6'h01
                    && fb_now <= {1'b0, `LOCK_WINDOW} + 6'h01) begin
                    if (st.good == `LOCK_GOOD_WINDOWS - 3'h1) begin
                        next_st.locked = 1'b1;
                    end else begin
                        next_st.good = st.good + 3'h1;
                    end
                end else begin
                    next_st.good = 3'h0;
                    next_st.locked = 1'b0;
                end
            end else begin
                next_st.ref_count = st.ref_count + 5'h01;
            end
        end
    end

    // register the state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign locked = st.locked;
endmodule

// *** verilog/pll_clock_ctrl.sv ***
// sampling-clock control: bypass or multiplier loop, dividers, lock flag, registers
// assumes the input pair and the feedback pulse are synchronous to clk_sys
// assumes a plain register port with read data one cycle after the read strobe
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "pll_clock_defines.svh"

// Contract
// - in bypass, one sample strobe per rising edge of the input pair
// - reference divided by one, two, four or eight before the detector
// - feedback divider of 16, 20, 24 or 28 returns to the detector
// - optional divide by two after the oscillator feeds the converter
// - oscillator factor is feedback over reference; overall divides by post setting
// - two oscillator bands selectable; in loop mode, high band without post divide only raises the rate-limit interrupt
// - lock flag in status register reads one when locked, zero otherwise
module pll_clock_ctrl
    import pll_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic diff_clock_input_pair_p,
    input wire logic diff_clock_input_pair_n,
    input wire logic vco_fb_pulse,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic irq,
    output logic converter_sample_clock,
    output logic vco_band_high,
    output logic loop_enable
);

    // ============================================================
    // state and helper signals
    top_state_t st;
    top_state_t next_st;
    logic in_level;
    logic in_rise;
    logic loop_locked;
    logic loop_lock_flag;
    logic [4:0] ref_ratio;
    logic [4:0] fb_ratio;
    logic [7:0] vco_factor_x4;
    logic [7:0] total_factor_x4;
    logic [31:0] loop_status_register;
    logic [2:0] irq_events;
    logic rate_limit_hit;
    logic ctrl_write;

    div_if ref_bus ();
    div_if fb_bus ();
    div_if post_bus ();

    // ============================================================
    // input clock edge detection
    // the pair is taken as a level: high when the true side leads
    assign in_level = diff_clock_input_pair_p & ~diff_clock_input_pair_n;
    // rising edge of the input pair
    assign in_rise = in_level & ~st.level_prev;

    // ============================================================
    // divider ratios from the control register
    always_comb begin
        unique case (st.ctrl.ref_sel)
            REF_DIV_1: ref_ratio = 5'h01;
            REF_DIV_2: ref_ratio = 5'h02;
            REF_DIV_4: ref_ratio = 5'h04;
            REF_DIV_8: ref_ratio = 5'h08;
        endcase
    end

    // feedback ratio steps by four from sixteen
    assign fb_ratio = `FB_RATIO_BASE + 5'(`FB_RATIO_STEP * 5'(st.ctrl.fb_sel));

    // ============================================================
    // multiplication factors, scaled by four so quarter steps stay exact
    // reference ratios are powers of two, so division is a shift
    assign vco_factor_x4 = 8'({3'h0, fb_ratio} << `FACTOR_SCALE_SHIFT) >> st.ctrl.ref_sel;
    // post divide halves the oscillator factor
    assign total_factor_x4 = vco_factor_x4 >> st.ctrl.post_div2;

    // ============================================================
    // reference divider: input edges to the detector
    assign ref_bus.tick_in = in_rise & st.ctrl.loop_en;
    assign ref_bus.ratio = ref_ratio;
    assign ref_bus.clear = st.clear;

    tick_divider u_ref_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .port(ref_bus.div)
    );

    // feedback divider: oscillator pulses back to the detector
    assign fb_bus.tick_in = vco_fb_pulse & st.ctrl.loop_en;
    assign fb_bus.ratio = fb_ratio;
    assign fb_bus.clear = st.clear;

    tick_divider u_fb_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .port(fb_bus.div)
    );

    // post divider: oscillator pulses to the converter, by one or two
    assign post_bus.tick_in = vco_fb_pulse & st.ctrl.loop_en;
    assign post_bus.ratio = st.ctrl.post_div2 ? 5'h02 : 5'h01;
    assign post_bus.clear = st.clear;

    tick_divider u_post_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .port(post_bus.div)
    );

    // ============================================================
    // lock detection on the divided pulse trains
    lock_detect u_lock (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clear(st.clear),
        .ref_tick(ref_bus.tick_out),
        .fb_tick(fb_bus.tick_out),
        .locked(loop_locked)
    );

    // lock is forced low in bypass where it means nothing
    assign loop_lock_flag = loop_locked & st.ctrl.loop_en;

    // ============================================================
    // status register image
    always_comb begin
        loop_status_register = 32'h0000_0000;
        loop_status_register[`STAT_BYPASS_BIT] = ~st.ctrl.loop_en;
        loop_status_register[`STAT_LOCK_BIT] = loop_lock_flag;
        loop_status_register[`STAT_VCO_LSB +: 8] = vco_factor_x4;
        loop_status_register[`STAT_TOTAL_LSB +: 8] = total_factor_x4;
    end

    // ============================================================
    // interrupt events
    // the high band undivided would pass the converter's top rate
    assign rate_limit_hit = st.ctrl.loop_en & st.ctrl.band_high & ~st.ctrl.post_div2;
    assign ctrl_write = wr_en && (addr == `REG_LOOP_CTRL);

    always_comb begin
        irq_events = 3'h0;
        irq_events[`IRQ_LOCK_GAINED] = loop_lock_flag & ~st.lock_prev;
        irq_events[`IRQ_LOCK_LOST] = ~loop_lock_flag & st.lock_prev;
        irq_events[`IRQ_RATE_LIMIT] = rate_limit_hit & st.clear;
    end

    // ============================================================
    // next state: register port, sample strobe, sticky flags
    always_comb begin
        next_st = st;
        next_st.level_prev = in_level;
        next_st.lock_prev = loop_lock_flag;
        next_st.clear = 1'b0;
        next_st.rdata = 32'h0000_0000;

        // register writes
        if (wr_en) begin
            unique case (addr)
                `REG_LOOP_CTRL: begin
                    next_st.ctrl = ctrl_t'(wdata[`CTRL_W-1:0]);
                end
                `REG_IRQ_MASK: begin
                    next_st.irq_mask = wdata[`IRQ_W-1:0];
                end
                default: begin
                    next_st.ctrl = st.ctrl;
                end
            endcase
        end

        // a new setting restarts the dividers and the lock search
        next_st.clear = ctrl_write;

        // register reads, data in the following cycle
        if (rd_en) begin
            unique case (addr)
                `REG_LOOP_CTRL: begin
                    next_st.rdata = {25'h0000000, st.ctrl};
                end
                `REG_LOOP_STATUS: begin
                    next_st.rdata = loop_status_register;
                end
                `REG_IRQ_STATUS: begin
                    next_st.rdata = {29'h00000000, st.irq_stat};
                end
                `REG_IRQ_MASK: begin
                    next_st.rdata = {29'h00000000, st.irq_mask};
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end

        // sticky flags: read clears, a new event wins over the clear
        if (rd_en && addr == `REG_IRQ_STATUS) begin
            next_st.irq_stat = irq_events;
        end else begin
            next_st.irq_stat = st.irq_stat | irq_events;
        end
        next_st.irq = |(next_st.irq_stat & st.irq_mask);

        // sampling strobe from the input edge or the post divider
        if (st.ctrl.loop_en) begin
            next_st.sample_out = post_bus.tick_out;
        end else begin
            next_st.sample_out = in_rise;
        end

        // drive the analog controls
        next_st.band_out = st.ctrl.band_high;
        next_st.loop_out = st.ctrl.loop_en;
    end

    // ============================================================
    // register the state
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // outputs, all straight from flip-flops
    assign rdata = st.rdata;
    assign irq = st.irq;
    assign converter_sample_clock = st.sample_out;
    assign vco_band_high = st.band_out;
    assign loop_enable = st.loop_out;

endmodule

// *** test/pll_clock_ctrl_asserts.sv ***
// checker for the sampling-clock control block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module pll_clock_ctrl_asserts (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic diff_clock_input_pair_p,
    input wire logic diff_clock_input_pair_n,
    input wire logic vco_fb_pulse,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic irq,
    input wire logic converter_sample_clock,
    input wire logic vco_band_high,
    input wire logic loop_enable
);
    // level of the input pair
    logic lvl;
    assign lvl = diff_clock_input_pair_p & ~diff_clock_input_pair_n;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // ============================================================
    // sample strobe
    bypass_strobe_a: assert property (
        $past(resetn) && !loop_enable && !$past(loop_enable) && lvl && !$past(lvl)
        ##1 !loop_enable |-> converter_sample_clock) else $error("missed bypass strobe");
    bypass_quiet_a: assert property (
        $past(resetn) && !loop_enable && !$past(loop_enable) && !(lvl && !$past(lvl))
        ##1 !loop_enable |-> !converter_sample_clock) else $error("stray bypass strobe");
    loop_quiet_a: assert property (
        loop_enable && $past(loop_enable) && !$past(vco_fb_pulse, 2)
        |-> !converter_sample_clock) else $error("strobe without oscillator pulse");
    // ============================================================
    // register port
    rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (
        rd_en && !(addr inside {4'h0, 4'h4, 4'h8, 4'hC}) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    lock_bypass_a: assert property (
        rd_en && addr == 4'h4 && !loop_enable && !$past(loop_enable)
        && !$past(loop_enable, 2) |=> !rdata[3]) else $error("lock flag in bypass");
    loop_follow_a: assert property (
        wr_en && addr == 4'h0 |=> ##1 loop_enable == $past(wdata[0], 2))
        else $error("loop enable not following control");
    band_follow_a: assert property (
        wr_en && addr == 4'h0 |=> ##1 vco_band_high == $past(wdata[6], 2))
        else $error("band select not following control");
endmodule
bind pll_clock_ctrl pll_clock_ctrl_asserts u_pll_clock_ctrl_asserts (.*);

// *** test/ref_clock_source.sv ***
// model of the external clock source: input pair and oscillator pulses
// assumes it is clocked by the bench clock; the pair stands still when off
`timescale 1ns/1ps
module ref_clock_source #(
    parameter int HALF = 8,
    parameter int FB_PER = 8
) (
    input wire logic clk_sys,
    input wire logic src_on,
    input wire logic fb_on,
    output logic pair_p,
    output logic pair_n,
    output logic fb_pulse
);
    int hc;
    int fc;
    initial begin
        pair_p = 1'b0;
        pair_n = 1'b1;
        fb_pulse = 1'b0;
        hc = 0;
        fc = 0;
    end
    // square wave on the pair, pulse train for feedback
    always @(posedge clk_sys) begin
        hc <= (hc == HALF - 1) ? 0 : hc + 1;
        fc <= (fc == FB_PER - 1) ? 0 : fc + 1;
        if (hc == HALF - 1) begin
            pair_p <= src_on & ~pair_p;
            pair_n <= ~(src_on & ~pair_p);
        end
        fb_pulse <= fb_on && fc == FB_PER - 1;
    end
endmodule

// *** test/pll_clock_ctrl_tb.sv ***
// bench for the sampling-clock control block
// assumes the clock source model and the bound checker
`timescale 1ns/1ps
module pll_clock_ctrl_tb;
    import pll_clock_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn, pp, pn, vco, wr_en, rd_en, irq, smp, band, lpen, src_on, fb_on, prev;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, d, e;
    int n_fail, compares, cycles, rises, samples, vpulses, i, r, f, p, v4;
    always #10 clk_sys = ~clk_sys;
    pll_clock_ctrl u_pll_clock_ctrl (.clk_sys(clk_sys), .resetn(resetn),
        .diff_clock_input_pair_p(pp), .diff_clock_input_pair_n(pn), .vco_fb_pulse(vco),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .irq(irq), .converter_sample_clock(smp), .vco_band_high(band), .loop_enable(lpen));
    ref_clock_source u_ref_clock_source (.clk_sys(clk_sys), .src_on(src_on),
        .fb_on(fb_on), .pair_p(pp), .pair_n(pn), .fb_pulse(vco));
    // ============================================================
    // tasks
    task wr(input logic [3:0] a, input logic [31:0] dv);
        @(posedge clk_sys);
        addr <= a;
        wdata <= dv;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] dv);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 dv = rdata;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict;
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ============================================================
    // counters of edges, strobes and pulses, and the run limit
    always @(posedge clk_sys) begin
        cycles++;
        if (pp & ~pn & ~prev) rises++;
        prev = pp & ~pn;
        if (smp === 1'b1) samples++;
        if (vco === 1'b1) vpulses++;
        if (cycles > 40000) begin
            n_fail++;
            print_verdict;
        end
    end
    // ============================================================
    // test sequence
    initial begin
        {resetn, wr_en, rd_en, src_on, fb_on, prev} = 6'h00;
        addr = 4'h0;
        wdata = 32'h0;
        {n_fail, compares, cycles, rises, samples, vpulses} = {6{32'sd0}};
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(4'h0, d); chk("ctrl reset", d, 32'h0);
        rd(4'h4, d); chk("status reset", d, 32'h00404001);
        wr(4'h2, 32'h0000007F);
        rd(4'h2, d); chk("unmapped read", d, 32'h0);
        rd(4'h0, d); chk("ctrl after unmapped write", d, 32'h0);
        // bypass: one strobe per rising pair edge
        src_on <= 1'b1;
        repeat (200) @(posedge clk_sys);
        src_on <= 1'b0;
        repeat (12) @(posedge clk_sys);
        chk("bypass strobes", samples, rises);
        chk("bypass edges seen", rises >= 10, 1);
        // every divider combination reported as factors times four
        for (i = 0; i < 32; i++) begin
            r = i % 4;
            f = (i / 4) % 4;
            p = i / 16;
            wr(4'h0, 1 | (r << 1) | (f << 3) | (p << 5));
            rd(4'h4, d);
            v4 = ((16 + 4 * f) * 4) >> r;
            e = ((v4 >> p) << 16) | (v4 << 8);
            chk("status factors", d & 32'h00FFFF01, e);
        end
        // rate warning on high band without post divide
        rd(4'h8, d);
        wr(4'hC, 32'h4);
        wr(4'h0, 32'h41);
        repeat (3) @(posedge clk_sys);
        #1 chk("rate irq", irq, 1);
        chk("band out", band, 1);
        chk("loop out", lpen, 1);
        rd(4'h8, d); chk("rate status", d, 32'h4);
        repeat (2) @(posedge clk_sys);
        #1 chk("irq after clear", irq, 0);
        // lock with ref /8, fb /16, post /2, oscillator in step with the pair
        wr(4'hC, 32'h2);
        wr(4'h0, 32'h27);
        repeat (2) @(posedge clk_sys);
        samples = 0;
        vpulses = 0;
        src_on <= 1'b1;
        fb_on <= 1'b1;
        d = 32'h0;
        for (i = 0; i < 150 && d[3] !== 1'b1; i++) begin
            repeat (100) @(posedge clk_sys);
            rd(4'h4, d);
        end
        chk("lock flag set", d[3], 1);
        chk("gained masked", irq, 0);
        rd(4'h8, d); chk("gained status", d, 32'h1);
        fb_on <= 1'b0;
        for (i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk_sys);
        #1 chk("lost irq", irq, 1);
        rd(4'h4, d); chk("lock flag clear", d[3], 0);
        rd(4'h8, d); chk("lost status", d, 32'h2);
        chk("post divided strobes", samples, vpulses / 2);
        print_verdict;
    end
endmodule
